// File: hw/flash_seq_pkg.sv
// constants and types for the flash programming sequencer
package flash_seq_pkg;
    localparam logic [3:0] REG_MAIN = 4'h0;
    localparam logic [3:0] REG_RSTPAT = 4'h1;
    localparam logic [3:0] REG_BUFCTL = 4'h2;
    localparam logic [3:0] REG_ADDR_LO = 4'h3;
    localparam logic [3:0] REG_ADDR_HI = 4'h4;
    localparam logic [3:0] REG_DATA0_LO = 4'h5;
    localparam logic [3:0] REG_DATA0_HI = 4'h6;
    localparam logic [3:0] REG_DATA3_HI = 4'hC;
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_ENABLE = 3'h6;
    localparam int BIT_ENABLED = 7;
    localparam int BIT_TRIG = 3;
    localparam int BIT_WR_GO = 2;
    localparam int BIT_RD_EN = 1;
    localparam int BIT_RD_GO = 0;
    localparam logic [7:0] CHIP_RST_KEY = 8'h55;
    localparam logic [4:0] LAST_WORD = 5'h1F;
    localparam logic [15:0] BLANK_WORD = 16'hFFFF;
    localparam logic [9:0] ENA_WIN_CYC = 10'h3FF;
    localparam logic [12:0] ADDR_RST = 13'h0000;
    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_ERASE, ST_WRITE, ST_CLR} state_e;
    typedef enum logic [1:0] {FL_READ, FL_ERASE, FL_WRITE} fl_cmd_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic req;
        fl_cmd_e cmd;
        logic [12:0] addr;
        logic [15:0] wdata;
    } flash_req_s;
    typedef struct packed {
        state_e st;
        logic enabled;
        logic [2:0] mode;
        logic trig;
        logic wr_go;
        logic rd_en;
        logic rd_go;
        logic clr_go;
        logic [9:0] timer;
        logic [7:0] rstpat;
        logic chip_rst;
        logic [12:0] addr;
        logic [3:0][15:0] dat;
        logic [31:0][15:0] wbuf;
        logic [4:0] idx;
        logic [7:0] rdata;
    } seq_state_s;
endpackage

// File: hw/iap_flash_sequencer.sv
// in-application flash programming sequencer: registers, write buffer, flash ops
`timescale 1ns/100ps
module iap_flash_sequencer #(
    // enable procedure patterns, arbitrary values
    parameter logic [15:0] KEY1 = 16'h0001,
    parameter logic [15:0] KEY2 = 16'h0002,
    parameter logic [15:0] KEY3 = 16'h0003
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire flash_seq_pkg::bus_req_s bus,
    output logic [7:0] rdata,
    output flash_seq_pkg::flash_req_s flash,
    input wire logic [15:0] fl_rdata,
    input wire logic fl_done,
    output logic cpu_stall,
    output logic chip_reset_req
);
    flash_seq_pkg::seq_state_s s;
    flash_seq_pkg::seq_state_s next_s;

    // data pair index for register offsets at or above the first data pair
    function automatic logic [1:0] pair_of(input logic [3:0] a);
        logic [3:0] d;
        d = a - flash_seq_pkg::REG_DATA0_LO;
        return d[2:1];
    endfunction

    function automatic logic is_data(input logic [3:0] a);
        return a >= flash_seq_pkg::REG_DATA0_LO && a <= flash_seq_pkg::REG_DATA3_HI;
    endfunction

    always_comb begin
        logic [1:0] p;
        logic hi;
        p = pair_of(bus.addr);
        hi = bus.addr[0] == flash_seq_pkg::REG_DATA0_HI[0];
        next_s = s;
        next_s.chip_rst = 1'b0;
        next_s.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                flash_seq_pkg::REG_MAIN: next_s.rdata = {s.enabled, s.mode, s.trig,
                    s.wr_go, s.rd_en, s.rd_go};
                flash_seq_pkg::REG_RSTPAT: next_s.rdata = s.rstpat;
                flash_seq_pkg::REG_BUFCTL: next_s.rdata = {7'h00, s.clr_go};
                flash_seq_pkg::REG_ADDR_LO: next_s.rdata = s.addr[7:0];
                flash_seq_pkg::REG_ADDR_HI: next_s.rdata = {3'h0, s.addr[12:8]};
                default: begin
                    if (is_data(bus.addr)) begin
                        next_s.rdata = hi ? s.dat[p][15:8] : s.dat[p][7:0];
                    end
                end
            endcase
        end
        if (bus.wr) begin
            case (bus.addr)
                flash_seq_pkg::REG_MAIN: begin
                    next_s.mode = bus.wdata[6:4];
                    next_s.rd_en = bus.wdata[flash_seq_pkg::BIT_RD_EN];
                    if (!bus.wdata[flash_seq_pkg::BIT_ENABLED]) begin
                        next_s.enabled = 1'b0;
                    end
                    if (bus.wdata[flash_seq_pkg::BIT_TRIG] && !s.trig &&
                        bus.wdata[6:4] == flash_seq_pkg::MODE_ENABLE) begin
                        next_s.trig = 1'b1;
                        next_s.timer = 10'h000;
                    end
                    if (s.st == flash_seq_pkg::ST_IDLE) begin
                        if (bus.wdata[flash_seq_pkg::BIT_RD_GO] && s.rd_en &&
                            bus.wdata[6:4] == flash_seq_pkg::MODE_READ) begin
                            next_s.rd_go = 1'b1;
                            next_s.st = flash_seq_pkg::ST_READ;
                        end else if (bus.wdata[flash_seq_pkg::BIT_WR_GO] && s.enabled &&
                            bus.wdata[6:4] == flash_seq_pkg::MODE_WRITE) begin
                            next_s.wr_go = 1'b1;
                            next_s.idx = 5'h00;
                            next_s.st = flash_seq_pkg::ST_WRITE;
                        end else if (bus.wdata[flash_seq_pkg::BIT_WR_GO] && s.enabled &&
                            bus.wdata[6:4] == flash_seq_pkg::MODE_ERASE) begin
                            next_s.wr_go = 1'b1;
                            next_s.st = flash_seq_pkg::ST_ERASE;
                        end
                    end
                end
                flash_seq_pkg::REG_RSTPAT: begin
                    next_s.rstpat = bus.wdata;
                    next_s.chip_rst = bus.wdata == flash_seq_pkg::CHIP_RST_KEY;
                end
                flash_seq_pkg::REG_BUFCTL: begin
                    if (bus.wdata[0] && s.st == flash_seq_pkg::ST_IDLE) begin
                        next_s.clr_go = 1'b1;
                        next_s.idx = 5'h00;
                        next_s.st = flash_seq_pkg::ST_CLR;
                    end
                end
                flash_seq_pkg::REG_ADDR_LO: next_s.addr[7:0] = bus.wdata;
                flash_seq_pkg::REG_ADDR_HI: next_s.addr[12:8] = bus.wdata[4:0];
                default: begin
                    if (is_data(bus.addr)) begin
                        if (hi) begin
                            next_s.dat[p][15:8] = bus.wdata;
                        end else begin
                            next_s.dat[p][7:0] = bus.wdata;
                        end
                    end
                    if (bus.addr == flash_seq_pkg::REG_DATA0_HI && s.enabled &&
                        s.st == flash_seq_pkg::ST_IDLE) begin
                        next_s.wbuf[s.addr[4:0]] = {bus.wdata, s.dat[0][7:0]};
                        if (s.addr[4:0] != flash_seq_pkg::LAST_WORD) begin
                            next_s.addr = s.addr + 13'h0001;
                        end
                    end
                end
            endcase
        end
        if (s.trig) begin
            next_s.timer = s.timer + 10'h001;
            if (s.timer == flash_seq_pkg::ENA_WIN_CYC) begin
                next_s.trig = 1'b0;
                // set after success; wins over a clear in the same cycle
                if (s.dat[1] == KEY1 && s.dat[2] == KEY2 && s.dat[3] == KEY3) begin
                    next_s.enabled = 1'b1;
                end
            end
        end
        case (s.st)
            flash_seq_pkg::ST_IDLE: begin
            end
            flash_seq_pkg::ST_READ: begin
                if (fl_done) begin
                    next_s.dat[0] = fl_rdata;
                    next_s.rd_go = 1'b0;
                    next_s.st = flash_seq_pkg::ST_IDLE;
                end
            end
            flash_seq_pkg::ST_ERASE: begin
                if (fl_done) begin
                    next_s.wr_go = 1'b0;
                    next_s.st = flash_seq_pkg::ST_IDLE;
                end
            end
            flash_seq_pkg::ST_WRITE: begin
                if (fl_done) begin
                    next_s.idx = s.idx + 5'h01;
                    if (s.idx == flash_seq_pkg::LAST_WORD) begin
                        next_s.st = flash_seq_pkg::ST_CLR;
                    end
                end
            end
            flash_seq_pkg::ST_CLR: begin
                // one word a cycle keeps the buffer a plain register bank
                next_s.wbuf[s.idx] = flash_seq_pkg::BLANK_WORD;
                next_s.idx = s.idx + 5'h01;
                if (s.idx == flash_seq_pkg::LAST_WORD) begin
                    next_s.clr_go = 1'b0;
                    next_s.wr_go = 1'b0;
                    next_s.st = flash_seq_pkg::ST_IDLE;
                end
            end
            default: next_s.st = flash_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= flash_seq_pkg::ST_IDLE;
            s.addr <= flash_seq_pkg::ADDR_RST;
            s.wbuf <= {32{flash_seq_pkg::BLANK_WORD}};
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        flash.req = s.st == flash_seq_pkg::ST_READ || s.st == flash_seq_pkg::ST_ERASE ||
            s.st == flash_seq_pkg::ST_WRITE;
        flash.cmd = flash_seq_pkg::FL_READ;
        flash.addr = s.addr;
        flash.wdata = 16'h0000;
        if (s.st == flash_seq_pkg::ST_ERASE) begin
            flash.cmd = flash_seq_pkg::FL_ERASE;
            flash.addr = {s.addr[12:5], 5'h00};
        end
        if (s.st == flash_seq_pkg::ST_WRITE) begin
            flash.cmd = flash_seq_pkg::FL_WRITE;
            flash.addr = {s.addr[12:5], s.idx};
            flash.wdata = s.wbuf[s.idx];
        end
    end

    assign rdata = s.rdata;
    // stall while busy; plain buffer clears stall too
    assign cpu_stall = s.st != flash_seq_pkg::ST_IDLE;
    assign chip_reset_req = s.chip_rst;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence d0h_load;
        bus.wr && bus.addr == flash_seq_pkg::REG_DATA0_HI && s.enabled &&
            s.st == flash_seq_pkg::ST_IDLE;
    endsequence
    sequence write_end;
        s.st == flash_seq_pkg::ST_WRITE && fl_done && s.idx == flash_seq_pkg::LAST_WORD;
    endsequence

    a_flag_from_timer: assert property ($rose(s.enabled) |-> $fell(s.trig))
        else $error("enabled flag rose without timer expiry");
    a_buffer_gated: assert property (bus.wr && bus.addr == flash_seq_pkg::REG_DATA0_HI &&
        !s.enabled && s.st == flash_seq_pkg::ST_IDLE |=> $stable(s.wbuf))
        else $error("buffer loaded while disabled");
    a_load_word: assert property (d0h_load |=>
        s.wbuf[$past(s.addr[4:0])] == {$past(bus.wdata), $past(s.dat[0][7:0])})
        else $error("buffer word wrong after high byte load");
    a_addr_step: assert property (d0h_load and s.addr[4:0] != flash_seq_pkg::LAST_WORD
        |=> s.addr == $past(s.addr) + 13'h0001)
        else $error("address did not advance");
    a_addr_hold: assert property (d0h_load and s.addr[4:0] == flash_seq_pkg::LAST_WORD
        |=> $stable(s.addr))
        else $error("address left page end");
    a_write_done: assert property (write_end |-> s.wr_go ##33 (!s.wr_go &&
        s.wbuf == {32{flash_seq_pkg::BLANK_WORD}}))
        else $error("write bit or buffer not cleared after page write");
    a_read_done: assert property (s.st == flash_seq_pkg::ST_READ && fl_done |=>
        !s.rd_go && s.dat[0] == $past(fl_rdata))
        else $error("read result not placed");
    a_erase_page: assert property (flash.cmd == flash_seq_pkg::FL_ERASE && flash.req
        |-> flash.addr == {s.addr[12:5], 5'h00})
        else $error("erase address not page aligned");
    a_stall_busy: assert property (cpu_stall |-> s.rd_go || s.wr_go || s.clr_go)
        else $error("stall without operation");
    a_clear_time: assert property ($rose(s.clr_go) |-> s.clr_go ##32 !s.clr_go)
        else $error("buffer clear bit timing wrong");

    sequence main_write;
        bus.wr && bus.addr == flash_seq_pkg::REG_MAIN;
    endsequence

    sequence timer_expiry;
        s.trig && s.timer == flash_seq_pkg::ENA_WIN_CYC;
    endsequence

    sequence key_match;
        s.dat[1] == KEY1 && s.dat[2] == KEY2 && s.dat[3] == KEY3;
    endsequence

    sequence read_end;
        s.st == flash_seq_pkg::ST_READ && fl_done;
    endsequence

    sequence clear_last;
        s.st == flash_seq_pkg::ST_CLR && s.idx == flash_seq_pkg::LAST_WORD;
    endsequence

    a_timer_expire: assert property (timer_expiry |=> !s.trig)
        else $error("trigger bit not cleared at timer expiry");

    // set must win even when software clears the flag in the same cycle
    a_key_enable: assert property (timer_expiry and key_match |=> s.enabled)
        else $error("flag not set after good enable procedure");

    a_flag_no_set: assert property (main_write ##0 (!s.enabled && !s.trig)
        |=> !s.enabled)
        else $error("software write set the enabled flag");

    a_trig_start: assert property (main_write ##0 (!s.trig &&
        bus.wdata[flash_seq_pkg::BIT_TRIG] && bus.wdata[6:4] == flash_seq_pkg::MODE_ENABLE)
        |=> s.trig && s.timer == 10'h000)
        else $error("enable timer did not start");

    a_rd_start: assert property ($rose(s.rd_go) |-> $past(s.rd_en) &&
        $past(s.st) == flash_seq_pkg::ST_IDLE)
        else $error("read started without read enable");

    a_rd_clear: assert property ($fell(s.rd_go) |-> $past(fl_done))
        else $error("read bit dropped before read finished");

    a_rd_finish: assert property (read_end |=> s.st == flash_seq_pkg::ST_IDLE)
        else $error("read state not left after completion");

    a_wr_start: assert property ($rose(s.wr_go) |-> $past(s.enabled))
        else $error("write or erase started while disabled");

    a_wr_stands: assert property (s.st == flash_seq_pkg::ST_WRITE ||
        s.st == flash_seq_pkg::ST_ERASE |-> s.wr_go)
        else $error("write bit low during operation");

    a_page_turn: assert property (write_end |=> s.st == flash_seq_pkg::ST_CLR)
        else $error("page write did not end after last word");

    a_word_step: assert property (s.st == flash_seq_pkg::ST_WRITE && fl_done &&
        s.idx != flash_seq_pkg::LAST_WORD
        |=> s.st == flash_seq_pkg::ST_WRITE && s.idx == $past(s.idx) + 5'h01)
        else $error("page write skipped a word");

    a_write_page: assert property (flash.req && flash.cmd == flash_seq_pkg::FL_WRITE
        |-> flash.addr[12:5] == s.addr[12:5] && flash.wdata == s.wbuf[s.idx])
        else $error("buffer word sent to wrong page");

    a_read_word: assert property (flash.req && flash.cmd == flash_seq_pkg::FL_READ
        |-> flash.addr == s.addr)
        else $error("read address differs from address registers");

    // the low byte alone must never reach the buffer
    a_low_only: assert property (bus.wr && bus.addr == flash_seq_pkg::REG_DATA0_LO &&
        s.st == flash_seq_pkg::ST_IDLE |=> $stable(s.wbuf))
        else $error("low byte write touched the buffer");

    a_clear_ends: assert property (clear_last |=> !s.clr_go &&
        s.st == flash_seq_pkg::ST_IDLE)
        else $error("buffer clear did not finish");

    a_buffer_blank: assert property (clear_last |=>
        s.wbuf == {32{flash_seq_pkg::BLANK_WORD}})
        else $error("buffer not blank after clear");

    a_stall_start: assert property ($rose(s.rd_go) || $rose(s.wr_go) |-> cpu_stall)
        else $error("operation started without stall");

    a_stall_end: assert property ($fell(cpu_stall) |-> !s.rd_go && !s.wr_go &&
        !s.clr_go)
        else $error("stall dropped with operation bit still set");

    a_erase_hold: assert property (s.st == flash_seq_pkg::ST_ERASE && !fl_done
        |=> s.st == flash_seq_pkg::ST_ERASE)
        else $error("erase left before flash completion");

    a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data not zero outside read cycle");

    a_addr_hi_read: assert property (bus.rd && bus.addr == flash_seq_pkg::REG_ADDR_HI
        |=> rdata[7:5] == 3'h0)
        else $error("unused address high bits read nonzero");
endmodule

// File: tb/flash_array_model.sv
// behavioural flash array answering the sequencer's flash requests
`timescale 1ns/100ps
module flash_array_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire flash_seq_pkg::flash_req_s flash,
    input wire logic [3:0] lat,
    output logic [15:0] fl_rdata,
    output logic fl_done
);
    logic [15:0] mem [0:8191];
    logic [3:0] cnt;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            fl_done <= 1'b0;
            fl_rdata <= 16'h0000;
            // cells start programmed to zero so a missing erase shows up
            for (int i = 0; i < 8192; i++) begin
                mem[i] = 16'h0000;
            end
        end else begin
            // data line toggles when not answering, never holds a stale word
            fl_rdata <= ~fl_rdata;
            fl_done <= 1'b0;
            if (flash.req && !fl_done) begin
                if (cnt < lat) begin
                    cnt <= cnt + 4'h1;
                end else begin
                    cnt <= 4'h0;
                    fl_done <= 1'b1;
                    case (flash.cmd)
                        flash_seq_pkg::FL_READ: fl_rdata <= mem[flash.addr];
                        flash_seq_pkg::FL_ERASE: begin
                            for (int i = 0; i < 32; i++) begin
                                mem[{flash.addr[12:5], i[4:0]}] = 16'hFFFF;
                            end
                        end
                        // programming only clears bits, so erase must come first
                        default: mem[flash.addr] = mem[flash.addr] & flash.wdata;
                    endcase
                end
            end
        end
    end
endmodule

// File: tb/iap_flash_sequencer_tb.sv
// self-checking bench for the flash programming sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module iap_flash_sequencer_tb;
    localparam logic [15:0] K1 = 16'h1234;
    localparam logic [15:0] K2 = 16'h5A6B;
    localparam logic [15:0] K3 = 16'hC3D2;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    flash_seq_pkg::bus_req_s bus = '0;
    logic [7:0] rdata;
    flash_seq_pkg::flash_req_s flash;
    logic [15:0] fl_rdata;
    logic fl_done;
    logic cpu_stall;
    logic chip_reset_req;
    logic [3:0] lat = 4'h0;
    logic [15:0] keys [0:2];
    int n_errors = 0;
    int n_tests = 0;
    always #12.5 clk_sys = ~clk_sys;
    iap_flash_sequencer #(.KEY1(K1), .KEY2(K2), .KEY3(K3)) dut_u (.clk_sys(clk_sys),
        .rst_n(rst_n), .bus(bus), .rdata(rdata), .flash(flash), .fl_rdata(fl_rdata),
        .fl_done(fl_done), .cpu_stall(cpu_stall), .chip_reset_req(chip_reset_req));
    flash_array_model fl_u (.clk_sys(clk_sys), .rst_n(rst_n), .flash(flash), .lat(lat),
        .fl_rdata(fl_rdata), .fl_done(fl_done));
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        `CHK(rdata, e)
        @(posedge clk_sys);
    endtask
    // bounded wait; the stall must already be up when it starts
    task automatic wait_idle();
        int i;
        i = 0;
        @(posedge clk_sys);
        #1;
        `CHK(cpu_stall, 1'b1)
        while (cpu_stall === 1'b1 && i < 3000) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        `CHK(i < 3000, 1'b1)
        @(posedge clk_sys);
    endtask
    task automatic t_regs();
        rd_chk(4'h0, 8'h00);
        rd_chk(4'hD, 8'h00);
        wr(4'h4, 8'hFF);
        rd_chk(4'h4, 8'h1F);
        #1;
        `CHK(rdata, 8'h00)
        @(posedge clk_sys);
        bus <= '{addr: 4'h1, wdata: flash_seq_pkg::CHIP_RST_KEY, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        `CHK(chip_reset_req, 1'b1)
        @(posedge clk_sys);
        #1;
        `CHK(chip_reset_req, 1'b0)
        @(posedge clk_sys);
        rd_chk(4'h1, 8'h55);
        wr(4'h0, 8'h80);
        rd_chk(4'h0, 8'h00);
    endtask
    task automatic t_enable();
        wr(4'h0, 8'h68);
        for (int k = 0; k < 3; k++) begin
            wr(4'h7 + 4'(2 * k), keys[k][7:0]);
            wr(4'h8 + 4'(2 * k), keys[k][15:8]);
        end
        rd_chk(4'h0, 8'h68);
        #1;
        `CHK(cpu_stall, 1'b0)
        repeat (1030) @(posedge clk_sys);
        rd_chk(4'h0, 8'hE0);
    endtask
    task automatic t_clear();
        wr(4'h2, 8'h01);
        wait_idle();
        rd_chk(4'h2, 8'h00);
    endtask
    task automatic t_erase();
        lat <= 4'h3;
        wr(4'h3, 8'hF7);
        wr(4'h4, 8'h1F);
        wr(4'h0, 8'h94);
        #1;
        `CHK(flash.cmd, flash_seq_pkg::FL_ERASE)
        `CHK(flash.addr, 13'h1FE0)
        wait_idle();
        `CHK(fl_u.mem[13'h1FFF], 16'hFFFF)
        `CHK(fl_u.mem[13'h1FDF], 16'h0000)
        rd_chk(4'h0, 8'h90);
    endtask
    task automatic t_write();
        wr(4'h3, 8'hE0);
        for (int i = 0; i < 32; i++) begin
            wr(4'h5, i[7:0]);
            wr(4'h6, 8'hA5);
            if (i == 0) rd_chk(4'h3, 8'hE1);
        end
        rd_chk(4'h3, 8'hFF);
        rd_chk(4'h4, 8'h1F);
        lat <= 4'h2;
        wr(4'h0, 8'h84);
        #1;
        `CHK(flash.cmd, flash_seq_pkg::FL_WRITE)
        `CHK(flash.wdata, 16'hA500)
        wait_idle();
        for (int i = 0; i < 32; i++) `CHK(fl_u.mem[13'h1FE0 + i], {8'hA5, i[7:0]})
        rd_chk(4'h0, 8'h80);
        wr(4'h0, 8'h84);
        #1;
        `CHK(flash.wdata, flash_seq_pkg::BLANK_WORD)
        `CHK(flash.addr, 13'h1FE0)
        wait_idle();
        // manual clear after the rewrite of the page from the blank buffer, before the read test
        wr(4'h2, 8'h01);
        wait_idle();
        rd_chk(4'h2, 8'h00);
    endtask
    task automatic t_read();
        lat <= 4'h5;
        wr(4'h3, 8'hE5);
        wr(4'h0, 8'hB2);
        wr(4'h0, 8'hB3);
        #1;
        `CHK(flash.cmd, flash_seq_pkg::FL_READ)
        `CHK(flash.addr, 13'h1FE5)
        wait_idle();
        rd_chk(4'h5, 8'h05);
        rd_chk(4'h6, 8'hA5);
        rd_chk(4'h0, 8'hB2);
        wr(4'h0, 8'hB0);
        wr(4'h0, 8'hB1);
        #1;
        `CHK(cpu_stall, 1'b0)
        @(posedge clk_sys);
        rd_chk(4'h0, 8'hB0);
    endtask
    task automatic t_disable();
        wr(4'h0, 8'h00);
        rd_chk(4'h0, 8'h00);
        wr(4'h3, 8'h10);
        wr(4'h5, 8'h11);
        wr(4'h6, 8'h22);
        rd_chk(4'h3, 8'h10);
    endtask
    initial begin
        keys[0] = K1;
        keys[1] = K2;
        keys[2] = K3;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_enable();
        // buffer is cleared before first use and the page erased before writing
        t_clear();
        t_erase();
        t_write();
        t_read();
        t_disable();
        conclude();
    end
    // whole run needs about 1700 cycles; this allows a wide margin
    initial begin
        #(25 * 8000);
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
endmodule
